/* inc/limit_defs_defs.svh */
// constants for the two-stage limit tester: formats, reset values, sizes
// assumes readings arrive as signed q16.16 fixed point words
`ifndef LIMIT_DEFS_DEFS_SVH
`define LIMIT_DEFS_DEFS_SVH

// ==========================================================
// number format
`define DATA_W      32
`define ONE_Q16     32'sh0001_0000
`define ZERO_Q16    32'sh0000_0000

// ==========================================================
// reset values
`define UB_RESET    32'sh0001_0000
`define LB_RESET    32'shffff_0000
`define OFF_RESET   32'sh0000_0000

// ==========================================================
// result store
`define RES_DEPTH   16
`define RES_AW      4
`define CNT_W       5
`define CNT_ONE     5'h01
`define CNT_ZERO    5'h00
`define CNT_MAX     5'h10
`define ENTRY_W     34

// ==========================================================
// error answer of a result query (-220, 16-bit two's complement)
`define ERR_NO_DATA 16'hff24
`define ERR_NONE    16'h0000

`endif

/* inc/limit_pkg.sv */
// types shared by the limit tester, its monitor and its bench
// assumes limit_defs_defs.svh is compiled alongside
package limit_pkg;

  // ==========================================================
  // verdict of one reading
  typedef enum logic [1:0] {
    VERDICT_NONE = 2'b00,
    VERDICT_OK   = 2'b01,
    VERDICT_L1   = 2'b10,
    VERDICT_L2   = 2'b11
  } verdict_t;

  // ==========================================================
  // configuration field selector
  typedef enum logic [3:0] {
    CFG_UB1    = 4'h0,
    CFG_LB1    = 4'h1,
    CFG_EN1    = 4'h2,
    CFG_UB2    = 4'h3,
    CFG_LB2    = 4'h4,
    CFG_EN2    = 4'h5,
    CFG_RELOFF = 4'h6,
    CFG_RELEN  = 4'h7,
    CFG_FEED   = 4'h8,
    CFG_ARM    = 4'h9
  } cfg_sel_t;

  // ==========================================================
  // control states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DUMP = 2'b10
  } state_t;

  typedef enum logic {
    FEED_SENSE = 1'b0,
    FEED_MATH  = 1'b1
  } feed_t;

  typedef enum logic {
    ARM_IMM   = 1'b0,
    ARM_OTHER = 1'b1
  } arm_t;

endpackage

/* rtl/result_mem.sv */
// small result store: one write port, one read port, registered read data
// assumes a single clock shared with the tester
`timescale 1ns/10ps
`include "limit_defs_defs.svh"

module result_mem (
  input  wire logic                  clk,
  input  wire logic                  wr_en,
  input  wire logic [`RES_AW-1:0]    wr_addr,
  input  wire logic [`ENTRY_W-1:0]   wr_data,
  input  wire logic [`RES_AW-1:0]    rd_addr,
  output logic      [`ENTRY_W-1:0]   rd_data_q
);

  logic [`ENTRY_W-1:0] mem_q [`RES_DEPTH];

  // array content has no reset; only entries below the count are read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data_q <= mem_q[rd_addr];
  end

endmodule // result_mem

/* rtl/two_stage_limit_tester.sv */
// two-stage limit tester: source select, rel offset, two band checks,
// result store and result queries
// assumes readings and commands come from logic on clk; the front key is a
// raw pin
//
// Operation
// - stage one checked first; its failure reports stage-one fail, ends test
// - stage one passed, stage two checked; failure reports stage-two fail
// - both stages passed reports overall pass
// - disabled stage is skipped, allowing single or two-stage tests
// - verdict hides which bound; upper/lower violation flags record it
// - with math active the math result is compared, not raw input
// - feed selector picks math result or sensed input; default sensed
// - each stage holds upper and lower bound; defaults one and minus one
// - each stage enable is writable alone and resets disabled
// - per-stage fail flag is 0 on pass and 1 on fail
// - rel offset, default zero, own enable off, applied before comparison
// - finite run: bulk query returns all results only after last reading
// - latest query returns only the most recent result
// - infinite run: bulk query refused; host aborts before latest query
// - query without readings or with limits disabled raises error -220
// - arm source defaults immediate; limit key press starts testing
// - second limit key press ends testing at any point
// - initiate starts one cycle of the programmed number of measurements; a count of zero runs one, counts above 16 run 16
// - abort cancels an initiated run and returns to idle at once
`timescale 1ns/10ps
`include "limit_defs_defs.svh"

module two_stage_limit_tester
  import limit_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        cfg_wr,
  input  wire logic [3:0]                  cfg_sel,
  input  wire logic [`DATA_W-1:0]          cfg_data,
  input  wire logic [`CNT_W-1:0]           meas_count,
  input  wire logic                        count_infinite,
  input  wire logic                        cmd_initiate,
  input  wire logic                        cmd_abort,
  input  wire logic                        cmd_fetch_all,
  input  wire logic                        cmd_fetch_latest,
  input  wire logic                        limit_key_pin,
  input  wire logic                        meas_valid,
  input  wire logic signed [`DATA_W-1:0]   sense_value,
  input  wire logic signed [`DATA_W-1:0]   math_value,
  output logic                             busy_q,
  output logic                             eval_q,
  output logic [1:0]                       verdict_q,
  output logic                             stage_one_fail_indication_q,
  output logic                             stage_two_fail_indication_q,
  output logic                             upper_viol_q,
  output logic                             lower_viol_q,
  output logic                             rd_valid_q,
  output logic                             rd_last_q,
  output logic signed [`DATA_W-1:0]        rd_data_q,
  output logic [1:0]                       rd_verdict_q,
  output logic                             err_q,
  output logic [15:0]                      err_code_q
);

  // ==========================================================
  // configuration
  logic signed [`DATA_W-1:0] ub1_q, ub1_d, lb1_q, lb1_d;
  logic signed [`DATA_W-1:0] ub2_q, ub2_d, lb2_q, lb2_d;
  logic signed [`DATA_W-1:0] off_q, off_d;
  logic                      en1_q, en1_d, en2_q, en2_d;
  logic                      rel_en_q, rel_en_d;
  feed_t                     feed_q, feed_d;
  arm_t                      arm_q, arm_d;

  always_comb begin
    ub1_d    = ub1_q;
    lb1_d    = lb1_q;
    ub2_d    = ub2_q;
    lb2_d    = lb2_q;
    off_d    = off_q;
    en1_d    = en1_q;
    en2_d    = en2_q;
    rel_en_d = rel_en_q;
    feed_d   = feed_q;
    arm_d    = arm_q;
    if (cfg_wr) begin
      case (cfg_sel)
        CFG_UB1:    ub1_d    = cfg_data;
        CFG_LB1:    lb1_d    = cfg_data;
        CFG_EN1:    en1_d    = cfg_data[0];
        CFG_UB2:    ub2_d    = cfg_data;
        CFG_LB2:    lb2_d    = cfg_data;
        CFG_EN2:    en2_d    = cfg_data[0];
        CFG_RELOFF: off_d    = cfg_data;
        CFG_RELEN:  rel_en_d = cfg_data[0];
        CFG_FEED:   feed_d   = feed_t'(cfg_data[0]);
        CFG_ARM:    arm_d    = arm_t'(cfg_data[0]);
        default:    ub1_d    = ub1_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ub1_q    <= `UB_RESET;
      lb1_q    <= `LB_RESET;
      ub2_q    <= `UB_RESET;
      lb2_q    <= `LB_RESET;
      off_q    <= `OFF_RESET;
      en1_q    <= 1'b0;
      en2_q    <= 1'b0;
      rel_en_q <= 1'b0;
      feed_q   <= FEED_SENSE;
      arm_q    <= ARM_IMM;
    end else begin
      ub1_q    <= ub1_d;
      lb1_q    <= lb1_d;
      ub2_q    <= ub2_d;
      lb2_q    <= lb2_d;
      off_q    <= off_d;
      en1_q    <= en1_d;
      en2_q    <= en2_d;
      rel_en_q <= rel_en_d;
      feed_q   <= feed_d;
      arm_q    <= arm_d;
    end
  end

  // ==========================================================
  // key synchroniser; the third stage only serves the edge detector
  logic key_s1_q, key_s2_q, key_s3_q;
  logic key_press;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_s1_q <= 1'b0;
      key_s2_q <= 1'b0;
      key_s3_q <= 1'b0;
    end else begin
      key_s1_q <= limit_key_pin;
      key_s2_q <= key_s1_q;
      key_s3_q <= key_s2_q;
    end
  end

  assign key_press = key_s2_q & ~key_s3_q;

  // ==========================================================
  // evaluation of one reading
  logic signed [`DATA_W-1:0] src_val, cmp_val;
  logic hi1, lo1, hi2, lo2, fail1, fail2;
  verdict_t verdict;

  always_comb begin
    // rel wraps on overflow; keep offsets well inside the q16.16 range
    src_val = (feed_q == FEED_MATH) ? math_value : sense_value;
    cmp_val = rel_en_q ? src_val - off_q : src_val;
    hi1     = cmp_val > ub1_q;
    lo1     = cmp_val < lb1_q;
    hi2     = cmp_val > ub2_q;
    lo2     = cmp_val < lb2_q;
    fail1   = en1_q & (hi1 | lo1);
    fail2   = ~fail1 & en2_q & (hi2 | lo2);
    if (fail1) begin
      verdict = VERDICT_L1;
    end else if (fail2) begin
      verdict = VERDICT_L2;
    end else begin
      verdict = VERDICT_OK;
    end
  end

  // ==========================================================
  // run control, store and queries
  state_t             st_q, st_d;
  logic [`CNT_W-1:0]  cnt_q, cnt_d, target;
  logic [`RES_AW-1:0] ptr_q, ptr_d;
  logic               inf_q, inf_d;
  logic               have_q, have_d;
  logic               busy_d, eval_d, f1_d, f2_d, up_d, lo_d;
  logic [1:0]         verdict_d;
  logic signed [`DATA_W-1:0] lat_q, lat_d;
  verdict_t           lat_v_q, lat_v_d;
  logic               pipe_q, pipe_d;
  logic               last_pipe_q, last_pipe_d;
  logic               lat_out_q, lat_out_d;
  logic               rd_valid_d, rd_last_d, err_d;
  logic signed [`DATA_W-1:0] rd_data_d;
  logic [1:0]         rd_verdict_d;
  logic [15:0]        err_code_d;
  logic               mem_wr;
  logic [`ENTRY_W-1:0] mem_q;
  logic               start, stop, limits_on;

  assign limits_on = en1_q | en2_q;
  assign target    = (meas_count == `CNT_ZERO) ? `CNT_ONE :
                     (meas_count > `CNT_MAX) ? `CNT_MAX : meas_count;
  // initiate while running is ignored; the run is already one cycle
  assign start     = (st_q == ST_IDLE) &
                     (cmd_initiate | (key_press & (arm_q == ARM_IMM)));
  assign stop      = (st_q == ST_RUN) & (cmd_abort | key_press);
  assign mem_wr    = (st_q == ST_RUN) & meas_valid & ~stop;

  always_comb begin
    st_d         = st_q;
    cnt_d        = cnt_q;
    ptr_d        = ptr_q;
    inf_d        = inf_q;
    have_d       = have_q;
    busy_d       = busy_q;
    eval_d       = 1'b0;
    verdict_d    = verdict_q;
    f1_d         = stage_one_fail_indication_q;
    f2_d         = stage_two_fail_indication_q;
    up_d         = upper_viol_q;
    lo_d         = lower_viol_q;
    lat_d        = lat_q;
    lat_v_d      = lat_v_q;
    pipe_d       = 1'b0;
    last_pipe_d  = 1'b0;
    lat_out_d    = 1'b0;
    err_d        = 1'b0;
    err_code_d   = err_code_q;
    rd_valid_d   = pipe_q | lat_out_q;
    rd_last_d    = last_pipe_q | lat_out_q;
    rd_data_d    = rd_data_q;
    rd_verdict_d = rd_verdict_q;
    // store data stand one cycle after their address, with the pipe flag
    if (pipe_q) begin
      rd_data_d    = mem_q[`DATA_W-1:0];
      rd_verdict_d = mem_q[`ENTRY_W-1:`DATA_W];
    end else if (lat_out_q) begin
      rd_data_d    = lat_q;
      rd_verdict_d = lat_v_q;
    end
    case (st_q)
      ST_IDLE: begin
        if (start) begin
          st_d   = ST_RUN;
          cnt_d  = `CNT_ZERO;
          inf_d  = count_infinite;
          have_d = 1'b0;
          busy_d = 1'b1;
        end else if (cmd_fetch_all) begin
          if (!have_q || !limits_on || inf_q) begin
            err_d      = 1'b1;
            err_code_d = `ERR_NO_DATA;
          end else begin
            st_d   = ST_DUMP;
            ptr_d  = '0;
            err_code_d = `ERR_NONE;
          end
        end else if (cmd_fetch_latest) begin
          if (!have_q || !limits_on) begin
            err_d      = 1'b1;
            err_code_d = `ERR_NO_DATA;
          end else begin
            lat_out_d  = 1'b1;
            err_code_d = `ERR_NONE;
          end
        end
      end
      ST_RUN: begin
        if (cmd_fetch_all || cmd_fetch_latest) begin
          // results stay hidden until the run is over
          err_d      = 1'b1;
          err_code_d = `ERR_NO_DATA;
        end
        if (stop) begin
          st_d   = ST_IDLE;
          busy_d = 1'b0;
        end else if (meas_valid) begin
          eval_d    = 1'b1;
          verdict_d = verdict;
          f1_d      = fail1;
          f2_d      = fail2;
          up_d      = fail1 ? hi1 : (fail2 & hi2);
          lo_d      = fail1 ? lo1 : (fail2 & lo2);
          lat_d     = cmp_val;
          lat_v_d   = verdict;
          have_d    = 1'b1;
          if (cnt_q < `CNT_MAX) begin
            cnt_d = cnt_q + `CNT_ONE;
          end
          if (!inf_q && (cnt_q + `CNT_ONE >= target)) begin
            st_d   = ST_IDLE;
            busy_d = 1'b0;
          end
        end
      end
      ST_DUMP: begin
        pipe_d    = 1'b1;
        ptr_d     = ptr_q + 1'b1;
        if ({1'b0, ptr_q} + `CNT_ONE >= cnt_q) begin
          last_pipe_d = 1'b1;
          st_d        = ST_IDLE;
        end
      end
      default: begin
        st_d   = ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q                        <= ST_IDLE;
      cnt_q                       <= `CNT_ZERO;
      ptr_q                       <= '0;
      inf_q                       <= 1'b0;
      have_q                      <= 1'b0;
      busy_q                      <= 1'b0;
      eval_q                      <= 1'b0;
      verdict_q                   <= VERDICT_NONE;
      stage_one_fail_indication_q <= 1'b0;
      stage_two_fail_indication_q <= 1'b0;
      upper_viol_q                <= 1'b0;
      lower_viol_q                <= 1'b0;
      lat_q                       <= `ZERO_Q16;
      lat_v_q                     <= VERDICT_NONE;
      pipe_q                      <= 1'b0;
      last_pipe_q                 <= 1'b0;
      lat_out_q                   <= 1'b0;
      rd_valid_q                  <= 1'b0;
      rd_last_q                   <= 1'b0;
      rd_data_q                   <= `ZERO_Q16;
      rd_verdict_q                <= VERDICT_NONE;
      err_q                       <= 1'b0;
      err_code_q                  <= `ERR_NONE;
    end else begin
      st_q                        <= st_d;
      cnt_q                       <= cnt_d;
      ptr_q                       <= ptr_d;
      inf_q                       <= inf_d;
      have_q                      <= have_d;
      busy_q                      <= busy_d;
      eval_q                      <= eval_d;
      verdict_q                   <= verdict_d;
      stage_one_fail_indication_q <= f1_d;
      stage_two_fail_indication_q <= f2_d;
      upper_viol_q                <= up_d;
      lower_viol_q                <= lo_d;
      lat_q                       <= lat_d;
      lat_v_q                     <= lat_v_d;
      pipe_q                      <= pipe_d;
      last_pipe_q                 <= last_pipe_d;
      lat_out_q                   <= lat_out_d;
      rd_valid_q                  <= rd_valid_d;
      rd_last_q                   <= rd_last_d;
      rd_data_q                   <= rd_data_d;
      rd_verdict_q                <= rd_verdict_d;
      err_q                       <= err_d;
      err_code_q                  <= err_code_d;
    end
  end

  // ==========================================================
  // result store; in an infinite run the write address sticks at 0 once the count saturates at 16
  result_mem u_store (
    .clk       (clk),
    .wr_en     (mem_wr),
    .wr_addr   (cnt_q[`RES_AW-1:0]),
    .wr_data   ({verdict, cmp_val}),
    .rd_addr   (ptr_q),
    .rd_data_q (mem_q)
  );

endmodule // two_stage_limit_tester

/* tb/limit_tester_monitor.sv */
// concurrent checks on the ports of the two-stage limit tester
// assumes the single clk domain and the async active-low rst_n
`timescale 1ns/10ps
`include "limit_defs_defs.svh"

module limit_tester_monitor
  import limit_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        cmd_initiate,
  input wire logic        cmd_abort,
  input wire logic        cmd_fetch_all,
  input wire logic        cmd_fetch_latest,
  input wire logic        meas_valid,
  input wire logic        busy_q,
  input wire logic        eval_q,
  input wire logic [1:0]  verdict_q,
  input wire logic        stage_one_fail_indication_q,
  input wire logic        stage_two_fail_indication_q,
  input wire logic        upper_viol_q,
  input wire logic        lower_viol_q,
  input wire logic        rd_valid_q,
  input wire logic        rd_last_q,
  input wire logic        err_q,
  input wire logic [15:0] err_code_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // query tracking
  // queries landing during a dump are dropped, so only judge idle ones
  logic pend_q;
  logic pend_d;
  logic ask;
  assign ask = !busy_q && !pend_q && !cmd_initiate;
  always_comb begin
    pend_d = pend_q;
    if (rd_last_q || err_q)
      pend_d = 1'b0;
    if (ask && (cmd_fetch_all || cmd_fetch_latest))
      pend_d = 1'b1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      pend_q <= 1'b0;
    else
      pend_q <= pend_d;
  end

  // ==========================================================
  // answers
  sequence ans_err;
    ##1 (err_q && err_code_q == `ERR_NO_DATA);
  endsequence
  sequence ans_latest;
    ##2 (rd_valid_q && rd_last_q);
  endsequence
  sequence ans_bulk;
    ##3 rd_valid_q;
  endsequence

  eval_cause_a: assert property (
    eval_q |-> $past(meas_valid) && $past(busy_q))
    else $error("evaluation without a reading in a run");
  stage_one_a: assert property (
    eval_q && verdict_q == VERDICT_L1 |-> stage_one_fail_indication_q &&
      !stage_two_fail_indication_q && (upper_viol_q ^ lower_viol_q))
    else $error("stage one failure flags wrong");
  stage_two_a: assert property (
    eval_q && verdict_q == VERDICT_L2 |-> stage_two_fail_indication_q &&
      !stage_one_fail_indication_q && (upper_viol_q ^ lower_viol_q))
    else $error("stage two failure flags wrong");
  pass_flags_a: assert property (
    eval_q && verdict_q == VERDICT_OK |-> !(stage_one_fail_indication_q ||
      stage_two_fail_indication_q || upper_viol_q || lower_viol_q))
    else $error("pass verdict with a fail flag");
  verdict_hold_a: assert property (
    !eval_q |-> verdict_q == $past(verdict_q))
    else $error("verdict moved without an evaluation");
  abort_idle_a: assert property (
    busy_q && cmd_abort |=> !busy_q)
    else $error("abort did not end the run");
  start_busy_a: assert property (
    !busy_q && !pend_q && cmd_initiate |=> busy_q)
    else $error("initiate did not start a run");
  latest_answer_a: assert property (
    ask && cmd_fetch_latest && !cmd_fetch_all |-> ans_latest or ans_err)
    else $error("latest query not answered in time");
  bulk_answer_a: assert property (
    ask && cmd_fetch_all |-> ans_bulk or ans_err)
    else $error("bulk query not answered in time");
  last_valid_a: assert property (
    rd_last_q |-> rd_valid_q)
    else $error("last marker without a returned reading");
endmodule // limit_tester_monitor

bind two_stage_limit_tester limit_tester_monitor limit_tester_monitor_inst (
  .clk, .rst_n, .cmd_initiate, .cmd_abort, .cmd_fetch_all,
  .cmd_fetch_latest, .meas_valid, .busy_q, .eval_q, .verdict_q,
  .stage_one_fail_indication_q, .stage_two_fail_indication_q,
  .upper_viol_q, .lower_viol_q, .rd_valid_q, .rd_last_q, .err_q,
  .err_code_q
);

/* tb/key_press_model.sv */
// front-panel key model: turns a press request into a held key level
// assumes requests are one-cycle pulses; the key rests low when released
`timescale 1ns/10ps

module key_press_model (
  input  wire logic clk,
  input  wire logic press_req,
  output logic      key_pin
);
  initial key_pin = 1'b0;
  // held for several cycles and off the edge, as a real finger would be
  always @(posedge clk) begin
    if (press_req) begin
      #3 key_pin = 1'b1;
      repeat (5) @(posedge clk);
      #4 key_pin = 1'b0;
    end
  end
endmodule // key_press_model

/* tb/two_stage_limit_tester_bench.sv */
// self-checking bench for the two-stage limit tester
// assumes q16.16 readings and the key model on the front key pin
`timescale 1ns/10ps
`include "limit_defs_defs.svh"

module two_stage_limit_tester_bench
  import limit_pkg::*;
;
  logic        clk, rst_n, cfg_wr, inf, meas_valid, key_req, key_pin;
  logic [3:0]  cfg_sel, cmd_v;
  logic [4:0]  cnt;
  logic [31:0] cfg_data, sense, math, rdat;
  logic        busy, eval, s1, s2, up, lo, rv, rl, err;
  logic [1:0]  vd, rvd;
  logic [15:0] ecode;
  logic [31:0] q[$];
  logic [1:0]  qv[$];
  int          mismatches, tests_run;

  two_stage_limit_tester two_stage_limit_tester_inst (
    .clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
    .cfg_data(cfg_data), .meas_count(cnt), .count_infinite(inf),
    .cmd_initiate(cmd_v[3]), .cmd_abort(cmd_v[2]),
    .cmd_fetch_all(cmd_v[1]), .cmd_fetch_latest(cmd_v[0]),
    .limit_key_pin(key_pin), .meas_valid(meas_valid),
    .sense_value(sense), .math_value(math), .busy_q(busy), .eval_q(eval),
    .verdict_q(vd), .stage_one_fail_indication_q(s1),
    .stage_two_fail_indication_q(s2), .upper_viol_q(up),
    .lower_viol_q(lo), .rd_valid_q(rv), .rd_last_q(rl), .rd_data_q(rdat),
    .rd_verdict_q(rvd), .err_q(err), .err_code_q(ecode));
  key_press_model key_press_model_inst (
    .clk(clk), .press_req(key_req), .key_pin(key_pin));

  // ==========================================================
  // shared tasks
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cfg(input logic [3:0] s, input logic [31:0] d);
    @(posedge clk) begin
      cfg_wr <= 1'b1;
      cfg_sel <= s;
      cfg_data <= d;
    end
    @(posedge clk) cfg_wr <= 1'b0;
  endtask
  // bits: initiate, abort, bulk query, latest query
  task automatic cmd(input logic [3:0] c);
    @(posedge clk) cmd_v <= c;
    @(posedge clk) cmd_v <= 4'h0;
  endtask
  task automatic start(input logic [4:0] n, input logic i);
    @(posedge clk) begin
      cnt <= n;
      inf <= i;
    end
    cmd(4'h8);
    @(posedge clk) #1 chk("busy", 1, busy);
  endtask
  // e packs verdict, stage one, stage two, upper, lower
  task automatic rd(input logic [31:0] s, input logic [5:0] e);
    @(posedge clk) begin
      meas_valid <= 1'b1;
      sense <= s;
    end
    @(posedge clk) meas_valid <= 1'b0;
    #1 chk("eval", 1, eval);
    chk("verdict_flags", e, {vd, s1, s2, up, lo});
  endtask
  task automatic qry_err(input logic [3:0] c);
    cmd(c);
    #1 chk("err", 1, err);
    chk("err_code", `ERR_NO_DATA, ecode);
  endtask
  task automatic fetch(input logic [3:0] c, input int n);
    int k;
    int t;
    k = 0;
    t = 0;
    cmd(c);
    while (k < n && t < 40) begin
      @(posedge clk) #1 t++;
      if (rv === 1'b1) begin
        chk("rd_data", q.pop_front(), rdat);
        chk("rd_last", k == n - 1, rl);
        chk("rd_verdict", qv.pop_front(), rvd);
        k++;
      end
    end
    chk("rd_count", n, k);
    chk("err_code", `ERR_NONE, ecode);
  endtask
  task automatic press(input logic v);
    int t;
    t = 0;
    @(posedge clk) key_req <= 1'b1;
    @(posedge clk) key_req <= 1'b0;
    while (busy !== v && t < 12) @(posedge clk) #1 t++;
    chk("busy", v, busy);
    repeat (8) @(posedge clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic s_reset;
    chk("busy", 0, busy);
    start(5'h01, 1'b0);
    rd(32'h0, 6'h10);
    chk("busy", 0, busy);
    qry_err(4'h1);
  endtask
  task automatic s_bounds;
    cfg(CFG_EN1, 32'h1);
    start(5'h04, 1'b0);
    rd(32'h0001_0000, 6'h10);
    rd(32'hffff_0000, 6'h10);
    rd(32'h0001_8000, 6'h2a);
    rd(32'hfffe_ffff, 6'h29);
  endtask
  task automatic s_two;
    cfg(CFG_UB1, 32'h0002_0000);
    cfg(CFG_LB1, 32'hfffe_0000);
    cfg(CFG_EN2, 32'h1);
    start(5'h04, 1'b0);
    rd(32'h0, 6'h10);
    rd(32'h0001_8000, 6'h36);
    rd(32'h0002_8000, 6'h2a);
    rd(32'hfffd_8000, 6'h29);
    q = '{32'h0, 32'h0001_8000, 32'h0002_8000, 32'hfffd_8000};
    qv = '{2'h1, 2'h3, 2'h2, 2'h2};
    fetch(4'h2, 4);
    q = '{32'hfffd_8000};
    qv = '{2'h2};
    fetch(4'h1, 1);
  endtask
  task automatic s_single;
    cfg(CFG_EN1, 32'h0);
    start(5'h01, 1'b0);
    rd(32'h0002_8000, 6'h36);
    cfg(CFG_EN1, 32'h1);
  endtask
  task automatic s_math;
    cfg(CFG_FEED, 32'h1);
    start(5'h02, 1'b0);
    @(posedge clk) math <= 32'h0001_8000;
    rd(32'h0, 6'h36);
    @(posedge clk) math <= 32'h0;
    rd(32'h0005_0000, 6'h10);
    cfg(CFG_FEED, 32'h0);
  endtask
  task automatic s_rel;
    cfg(CFG_RELOFF, 32'h0002_0000);
    cfg(CFG_RELEN, 32'h1);
    start(5'h02, 1'b0);
    rd(32'h0002_8000, 6'h10);
    rd(32'h0, 6'h35);
    cfg(CFG_RELEN, 32'h0);
  endtask
  task automatic s_abort;
    start(5'h01, 1'b1);
    rd(32'h0000_8000, 6'h10);
    rd(32'h0001_8000, 6'h36);
    chk("busy", 1, busy);
    cmd(4'h4);
    #1 chk("busy", 0, busy);
    @(posedge clk) meas_valid <= 1'b1;
    @(posedge clk) meas_valid <= 1'b0;
    #1 chk("eval", 0, eval);
    qry_err(4'h2);
    q = '{32'h0001_8000};
    qv = '{2'h3};
    fetch(4'h1, 1);
  endtask

  // ==========================================================
  // clock, sequence, watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    {cfg_wr, inf, meas_valid, key_req} = 4'h0;
    {cfg_sel, cmd_v, cnt} = 13'h0;
    {cfg_data, sense, math} = 96'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    s_reset;
    s_bounds;
    s_two;
    s_single;
    s_math;
    s_rel;
    s_abort;
    cfg(CFG_ARM, 32'h1);
    press(1'b0);
    chk("busy", 0, busy);
    cfg(CFG_ARM, 32'h0);
    press(1'b1);
    press(1'b0);
    wrap_up;
  end
  // the tests need well under a thousand cycles
  initial begin
    #50000;
    mismatches++;
    wrap_up;
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
endmodule // two_stage_limit_tester_bench
